// ==== hdl/hof_pkg.sv ====
/*
 * hof_pkg: constants, register map and carrier types of the hall output
 * filter and clamp block.
 * assumes a single 100 MHz system clock and a plain strobe register port.
 */
package hof_pkg;

	// clock and sample rates
	localparam int CLK_HZ         = 100_000_000;
	localparam int DSP_RATE_HZ    = 16_000;
	localparam int DAC_RATE_HZ    = 256_000;
	localparam int DSP_PERIOD_CYC = CLK_HZ / DSP_RATE_HZ;      // 6250 cycles
	localparam int DAC_PERIOD_CYC = CLK_HZ / DAC_RATE_HZ;      // 390, rounded down
	localparam int INTERP_STEPS   = DAC_RATE_HZ / DSP_RATE_HZ; // 16 dac ticks per dsp sample
	localparam int INTERP_SHIFT   = 4;

	// data widths
	localparam int SAMPLE_W = 16;
	localparam int RESULT_W = 18;
	localparam int CODE_W   = 12;
	localparam int FRAC_W   = 8;
	localparam int ACC_W    = SAMPLE_W + FRAC_W + 1;
	localparam int IACC_W   = CODE_W + INTERP_SHIFT;
	localparam int CNT_W    = 16;
	localparam logic [CODE_W-1:0] CODE_MAX = 12'hfff;

	// filter select codes and shift per code (nominal corners 78..1320 Hz)
	localparam logic [2:0]  SEL_OFF      = 3'h7;
	localparam logic [27:0] LP_SHIFT_TAB = {4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h5};

	// register indices on the port
	localparam int ADDR_W = 3;
	localparam logic [ADDR_W-1:0] ADDR_FILTER_SEL = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_LOWER      = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_UPPER      = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = 3'h4;
	localparam logic [ADDR_W-1:0] ADDR_DIAG       = 3'h5;
	localparam logic [ADDR_W-1:0] ADDR_CODE       = 3'h6;
	localparam int DATA_W = 16;

	// values after reset
	localparam logic [2:0]        RST_FILTER_SEL = 3'h0;
	localparam logic [CODE_W-1:0] RST_LOWER      = 12'h000;
	localparam logic [CODE_W-1:0] RST_UPPER      = 12'hfff;

	// interrupt status bits
	localparam int IRQ_W         = 4;
	localparam int IRQ_SUPPLY    = 0;
	localparam int IRQ_MEM_FIXED = 1;
	localparam int IRQ_MEM_FATAL = 2;
	localparam int IRQ_CLAMP     = 3;

	// interpolator states
	typedef enum logic [1:0] {
		HOF_IDLE = 2'b01,
		HOF_RAMP = 2'b10
	} hof_interp_e;

	// register port request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} hof_bus_s;

	// all state of the block
	typedef struct packed {
		logic [2:0]                 filterSel;
		logic [CODE_W-1:0]          lowerLimit;
		logic [CODE_W-1:0]          upperLimit;
		logic [IRQ_W-1:0]           irqStatus;
		logic [IRQ_W-1:0]           irqMask;
		logic [DATA_W-1:0]          rdData;
		logic                       irq;
		logic signed [ACC_W-1:0]    lpAcc;
		logic [CNT_W-1:0]           dspCnt;
		logic signed [SAMPLE_W-1:0] dspSample;
		logic                       dspValid;
		logic [CNT_W-1:0]           dacCnt;
		hof_interp_e                interpState;
		logic [IACC_W-1:0]          interpAcc;
		logic signed [IACC_W:0]     interpStep;
		logic [CODE_W-1:0]          interpTarget;
		logic [4:0]                 stepCnt;
		logic [CODE_W-1:0]          dacCode;
		logic                       dacValid;
		logic                       memFatal;
		logic                       clampHit;
	} hof_state_s;

endpackage : hof_pkg

// ==== hdl/hof_filter_clamp.sv ====
/*
 * hof_filter_clamp: input low-pass filter, dsp result limiter, dac
 * interpolation filter, output clamp and error override, with registers.
 * register map by index: 0 filter select, 1 lower limit, 2 upper limit,
 * 3 interrupt status (write one to clear), 4 interrupt mask,
 * 5 diagnostics (read only), 6 current output code (read only);
 * unmapped indices read zero and drop writes.
 * each supply and memory fault bit sets on every cycle its cause is present,
 * the clamp bit only on dac ticks that clamp, and a new event wins over a clear written in the same cycle.
 * the interpolator ramps in sixteen output ticks towards each new
 * result; a result that lands mid-ramp restarts it from where it is.
 * a fault on two or more memory lines latches until reset, so the
 * output stays at full scale even after the lines read clean again.
 * the clamp has no enable: limits parked at 0x000 and 0xfff let the
 * whole code range through.
 * assumes converter samples, dsp results and fault flags synchronous to
 * sys_clk; the dsp sits outside and returns one result per sample.
 */
//
// Contract
// - low-pass has unity dc gain exactly
// - three-bit select gives eight filter settings; codes 1/2, 3/4 and 5/6 share a shift here, five distinct
// - select seven passes samples unfiltered
// - filtered samples reach dsp at 16 kHz
// - interpolator always on, 256 kHz output
// - out of range output held at clamp
// - two 12-bit clamp codes, code over 4096
// - lower above upper lets upper win
// - single line memory error gets corrected
// - errors in two lines force full output
// - supply under or over forces high
// - adjusted signal limited to 12 bits
`timescale 1ns/1ns
module hof_filter_clamp #(
	parameter int DSP_PERIOD = hof_pkg::DSP_PERIOD_CYC,
	parameter int DAC_PERIOD = hof_pkg::DAC_PERIOD_CYC,
	parameter int NUM_LINES  = 8
) (
	// clock and reset
	input  wire logic                                 sys_clk,
	input  wire logic                                 rst_b,
	// register port
	input  wire logic [hof_pkg::ADDR_W-1:0]           regAddr,
	input  wire logic [hof_pkg::DATA_W-1:0]           regWdata,
	input  wire logic                                 regWr,
	input  wire logic                                 regRd,
	output logic      [hof_pkg::DATA_W-1:0]           regRdata,
	output logic                                      irq,
	// hall converter samples
	input  wire logic signed [hof_pkg::SAMPLE_W-1:0]  adcSample,
	input  wire logic                                 adcValid,
	// dsp input and result
	output logic signed [hof_pkg::SAMPLE_W-1:0]       dspSample,
	output logic                                      dspValid,
	input  wire logic signed [hof_pkg::RESULT_W-1:0]  dspResult,
	input  wire logic                                 dspResultValid,
	// diagnostics inputs
	input  wire logic                                 supplyUnder,
	input  wire logic                                 supplyOver,
	input  wire logic [NUM_LINES-1:0]                 memLineErr,
	// dac output
	output logic [hof_pkg::CODE_W-1:0]                dacCode,
	output logic                                      dacValid
);

	// refuse settings the counters cannot serve, at elaboration
	if (DSP_PERIOD < 2 || DSP_PERIOD >= (1 << hof_pkg::CNT_W))
	begin : g_bad_dsp_period
		$error("DSP_PERIOD out of range");
	end
	if (DAC_PERIOD < 1 || DAC_PERIOD >= (1 << hof_pkg::CNT_W))
	begin : g_bad_dac_period
		$error("DAC_PERIOD out of range");
	end
	if (NUM_LINES < 2 || NUM_LINES > 255)
	begin : g_bad_num_lines
		$error("NUM_LINES out of range");
	end
	// the ramp counter is five bits and the step is a plain shift
	if (hof_pkg::INTERP_STEPS != (1 << hof_pkg::INTERP_SHIFT) || hof_pkg::INTERP_STEPS > 31)
	begin : g_bad_interp
		$error("interpolation steps do not match the shift");
	end

	// last counts of the tick counters and the rounding offset
	localparam logic [hof_pkg::CNT_W-1:0] DSP_LAST = hof_pkg::CNT_W'(DSP_PERIOD - 1);
	localparam logic [hof_pkg::CNT_W-1:0] DAC_LAST = hof_pkg::CNT_W'(DAC_PERIOD - 1);
	localparam logic signed [hof_pkg::ACC_W-1:0] ROUND_HALF =
		hof_pkg::ACC_W'(1 << (hof_pkg::FRAC_W - 1));

	// registered state, its next value and the request bundle
	hof_pkg::hof_state_s s_reg;
	hof_pkg::hof_state_s s_next;
	hof_pkg::hof_bus_s   bus;

	// request bundle
	assign bus.wr    = regWr;
	assign bus.rd    = regRd;
	assign bus.addr  = regAddr;
	assign bus.wdata = regWdata;

	// combinational helpers
	logic signed [hof_pkg::ACC_W-1:0] xScaled;
	logic signed [hof_pkg::ACC_W-1:0] lpDiff;
	logic signed [hof_pkg::ACC_W-1:0] lpRound;
	logic [3:0]                       lpShift;
	logic [7:0]                       errLines;
	logic signed [hof_pkg::RESULT_W-1:0] limitedRes;
	logic [hof_pkg::CODE_W-1:0]       limCode;
	logic [hof_pkg::CODE_W-1:0]       rawCode;
	logic [hof_pkg::CODE_W-1:0]       lowClamped;
	logic [hof_pkg::CODE_W-1:0]       clampCode;
	logic                             clampActive;
	logic                             supplyFault;
	logic                             memFixed;
	logic                             memFatalNow;
	logic                             dspTick;
	logic                             dacTick;
	logic signed [hof_pkg::IACC_W:0]  rampDiff;
	logic [hof_pkg::IRQ_W-1:0]        irqEvents;
	logic [hof_pkg::IRQ_W-1:0]        irqClear;
	logic                             errOverride;
	logic [hof_pkg::DATA_W-1:0]       rdMux;

	// count memory lines that report a parity error
	always_comb
	begin
		errLines = 8'h00;
		for (int i = 0; i < NUM_LINES; i++)
			errLines = errLines + {7'h00, memLineErr[i]};
	end

	// low-pass filter arithmetic, sample scaled into fraction bits
	always_comb
	begin
		xScaled = hof_pkg::ACC_W'(adcSample) <<< hof_pkg::FRAC_W;
		lpDiff  = xScaled - s_reg.lpAcc;
		if (s_reg.filterSel == hof_pkg::SEL_OFF)
			lpShift = 4'h0;
		else
			lpShift = hof_pkg::LP_SHIFT_TAB[{s_reg.filterSel[2:0], 2'b00} +: 4];
		lpRound = (s_reg.lpAcc + ROUND_HALF) >>> hof_pkg::FRAC_W;
	end

	// dsp result limiter to an unsigned 12-bit code
	always_comb
	begin
		limitedRes = dspResult;
		if (dspResult < 0)
			limCode = 12'h000;
		else if (dspResult > hof_pkg::RESULT_W'(hof_pkg::CODE_MAX))
			limCode = hof_pkg::CODE_MAX;
		else
			limCode = limitedRes[hof_pkg::CODE_W-1:0];
	end

	// ramp step towards the new target, sixteen ticks per result
	always_comb
	begin
		rampDiff = $signed({1'b0, limCode, 4'h0}) - $signed({1'b0, s_reg.interpAcc});
	end

	// clamp, lower first so upper wins when limits cross
	always_comb
	begin
		rawCode     = s_reg.interpAcc[hof_pkg::IACC_W-1 -: hof_pkg::CODE_W];
		lowClamped  = (rawCode < s_reg.lowerLimit) ? s_reg.lowerLimit : rawCode;
		clampCode   = (lowClamped > s_reg.upperLimit) ? s_reg.upperLimit : lowClamped;
		clampActive = (clampCode != rawCode);
	end

	// diagnostics and tick decode
	always_comb
	begin
		supplyFault = supplyUnder | supplyOver;
		memFixed    = (errLines == 8'h01);
		memFatalNow = (errLines > 8'h01);
		dspTick     = (s_reg.dspCnt == DSP_LAST);
		dacTick     = (s_reg.dacCnt == DAC_LAST);
	end

	// error override, a supply or fatal memory fault beats any clamped code
	always_comb
	begin
		errOverride = supplyFault | s_reg.memFatal | memFatalNow;
	end

	// interrupt events and write-one-to-clear mask
	always_comb
	begin
		irqEvents = '0;
		irqEvents[hof_pkg::IRQ_SUPPLY]    = supplyFault;
		irqEvents[hof_pkg::IRQ_MEM_FIXED] = memFixed;
		irqEvents[hof_pkg::IRQ_MEM_FATAL] = memFatalNow;
		irqEvents[hof_pkg::IRQ_CLAMP]     = dacTick & clampActive;
		irqClear = '0;
		if (bus.wr && bus.addr == hof_pkg::ADDR_IRQ_STATUS)
			irqClear = bus.wdata[hof_pkg::IRQ_W-1:0];
	end

	// read multiplexer, unmapped indices read zero
	always_comb
	begin
		case (bus.addr)
			hof_pkg::ADDR_FILTER_SEL: rdMux = {13'h0, s_reg.filterSel};
			hof_pkg::ADDR_LOWER:      rdMux = {4'h0, s_reg.lowerLimit};
			hof_pkg::ADDR_UPPER:      rdMux = {4'h0, s_reg.upperLimit};
			hof_pkg::ADDR_IRQ_STATUS: rdMux = {12'h000, s_reg.irqStatus};
			hof_pkg::ADDR_IRQ_MASK:   rdMux = {12'h000, s_reg.irqMask};
			hof_pkg::ADDR_DIAG:       rdMux = {12'h000, s_reg.clampHit,
				s_reg.memFatal, memFixed, supplyFault};
			hof_pkg::ADDR_CODE:       rdMux = {4'h0, s_reg.dacCode};
			default:                  rdMux = '0;
		endcase
	end

	// next state
	always_comb
	begin
		s_next          = s_reg;
		s_next.dspValid = 1'b0;
		s_next.dacValid = 1'b0;
		s_next.rdData   = '0;

		// register writes
		if (bus.wr)
		begin
			case (bus.addr)
				hof_pkg::ADDR_FILTER_SEL: s_next.filterSel  = bus.wdata[2:0];
				hof_pkg::ADDR_LOWER:      s_next.lowerLimit = bus.wdata[11:0];
				hof_pkg::ADDR_UPPER:      s_next.upperLimit = bus.wdata[11:0];
				hof_pkg::ADDR_IRQ_MASK:   s_next.irqMask    = bus.wdata[hof_pkg::IRQ_W-1:0];
				default:                  s_next.rdData     = '0;
			endcase
		end

		// register reads, data stand in the following cycle
		if (bus.rd)
			s_next.rdData = rdMux;

		// sticky status, a new event beats a clear in the same cycle
		s_next.irqStatus = (s_reg.irqStatus & ~irqClear) | irqEvents;
		s_next.irq       = |(s_next.irqStatus & s_next.irqMask);

		// uncorrectable memory stays fatal until reset
		if (memFatalNow)
			s_next.memFatal = 1'b1;

		// low-pass update on each converter sample
		if (adcValid)
		begin
			if (s_reg.filterSel == hof_pkg::SEL_OFF)
				s_next.lpAcc = xScaled;
			else
				s_next.lpAcc = s_reg.lpAcc + (lpDiff >>> lpShift);
		end

		// decimated hand-over to the dsp
		if (dspTick)
		begin
			s_next.dspCnt    = '0;
			s_next.dspValid  = 1'b1;
			s_next.dspSample = lpRound[hof_pkg::SAMPLE_W-1:0];
		end
		else
			s_next.dspCnt = s_reg.dspCnt + 1'b1;

		// dac tick counter runs free
		if (dacTick)
			s_next.dacCnt = '0;
		else
			s_next.dacCnt = s_reg.dacCnt + 1'b1;

		// interpolator, a new result restarts the ramp from where it stands
		case (s_reg.interpState)
			hof_pkg::HOF_IDLE:
			begin
				s_next.interpState = hof_pkg::HOF_IDLE;
			end
			hof_pkg::HOF_RAMP:
			begin
				if (dacTick)
				begin
					s_next.interpAcc = hof_pkg::IACC_W'($signed({1'b0, s_reg.interpAcc})
						+ s_reg.interpStep);
					s_next.stepCnt = s_reg.stepCnt - 1'b1;
					if (s_reg.stepCnt == 5'h01)
					begin
						s_next.interpAcc   = {s_reg.interpTarget, 4'h0};
						s_next.interpState = hof_pkg::HOF_IDLE;
					end
				end
			end
			default:
			begin
				s_next.interpState = hof_pkg::HOF_IDLE;
			end
		endcase
		if (dspResultValid)
		begin
			s_next.interpTarget = limCode;
			s_next.interpStep   = rampDiff >>> hof_pkg::INTERP_SHIFT;
			s_next.stepCnt      = 5'(hof_pkg::INTERP_STEPS);
			s_next.interpState  = hof_pkg::HOF_RAMP;
		end

		// output sample: clamp then error override
		if (dacTick)
		begin
			s_next.dacValid = 1'b1;
			s_next.clampHit = clampActive;
			if (errOverride)
				s_next.dacCode = hof_pkg::CODE_MAX;
			else
				s_next.dacCode = clampCode;
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_reg              <= '0;
			s_reg.filterSel    <= hof_pkg::RST_FILTER_SEL;
			s_reg.lowerLimit   <= hof_pkg::RST_LOWER;
			s_reg.upperLimit   <= hof_pkg::RST_UPPER;
			s_reg.interpState  <= hof_pkg::HOF_IDLE;
		end
		else
			s_reg <= s_next;
	end

	// outputs straight from the state register
	assign regRdata  = s_reg.rdData;
	assign irq       = s_reg.irq;
	assign dspSample = s_reg.dspSample;
	assign dspValid  = s_reg.dspValid;
	assign dacCode   = s_reg.dacCode;
	assign dacValid  = s_reg.dacValid;

endmodule : hof_filter_clamp

// ==== verification/hof_filter_clamp_asserts.sv ====
/* hof_filter_clamp_asserts: port checks on the filter and clamp block.
 * assumes the clamp limits change only through writes on the register port. */
`timescale 1ns/1ns
module hof_filter_clamp_asserts #(
	parameter int DSP_PERIOD = 64,
	parameter int DAC_PERIOD = 4,
	parameter int NUM_LINES  = 8
) (
	// clock and reset
	input wire logic                                sys_clk,
	input wire logic                                rst_b,
	// register port
	input wire logic [hof_pkg::ADDR_W-1:0]          regAddr,
	input wire logic [hof_pkg::DATA_W-1:0]          regWdata,
	input wire logic                                regWr,
	input wire logic                                regRd,
	input wire logic [hof_pkg::DATA_W-1:0]          regRdata,
	// streams and faults
	input wire logic signed [hof_pkg::SAMPLE_W-1:0] dspSample,
	input wire logic                                dspValid,
	input wire logic                                supplyUnder,
	input wire logic                                supplyOver,
	input wire logic [NUM_LINES-1:0]                memLineErr,
	input wire logic [hof_pkg::CODE_W-1:0]          dacCode,
	input wire logic                                dacValid
);
	logic [11:0] loLim;
	logic [11:0] hiLim;
	logic        fatalSeen;
	logic        okNow;

	// no supply fault, no latched fatal and fewer than two memory lines in error
	assign okNow = !supplyUnder && !supplyOver && !fatalSeen && ($countones(memLineErr) < 2);

	// shadow of the limits and the fatal latch
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			loLim     <= 12'h000;
			hiLim     <= 12'hfff;
			fatalSeen <= 1'b0;
		end
		else
		begin
			if (regWr && regAddr == hof_pkg::ADDR_LOWER)
				loLim <= regWdata[11:0];
			if (regWr && regAddr == hof_pkg::ADDR_UPPER)
				hiLim <= regWdata[11:0];
			if ($countones(memLineErr) > 1)
				fatalSeen <= 1'b1;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	a_dac_hold: assert property ($changed(dacCode) |-> dacValid)
		else $error("dac code moved off tick");
	a_dac_period: assert property (dacValid |-> ##DAC_PERIOD dacValid)
		else $error("dac tick spacing wrong");
	a_dsp_period: assert property (dspValid |-> ##DSP_PERIOD dspValid)
		else $error("dsp tick spacing wrong");
	a_dsp_hold: assert property ($changed(dspSample) |-> dspValid)
		else $error("dsp sample moved off tick");
	a_supply_high: assert property (dacValid && $past(supplyUnder || supplyOver)
		&& $past(supplyUnder || supplyOver, 2) |-> dacCode == 12'hfff)
		else $error("supply fault not at high level");
	a_mem_fatal: assert property (dacValid && $past(fatalSeen) |-> dacCode == 12'hfff)
		else $error("memory fault not at high level");
	a_clamp_window: assert property (dacValid && $past(okNow) && $past(okNow, 2)
		&& !$past(regWr) && !$past(regWr, 2) |-> (loLim > hiLim) ? dacCode == hiLim
		: (dacCode >= loLim && dacCode <= hiLim))
		else $error("output code outside limits");
	a_read_quiet: assert property (!$past(regRd) |-> regRdata == 16'h0000)
		else $error("read data outside read slot");

	c_supply: cover property (dacValid && supplyOver);
	c_upper_wins: cover property (dacValid && loLim > hiLim);
	c_fatal: cover property (dacValid && fatalSeen);
endmodule : hof_filter_clamp_asserts

bind hof_filter_clamp hof_filter_clamp_asserts #(
	.DSP_PERIOD(DSP_PERIOD),
	.DAC_PERIOD(DAC_PERIOD),
	.NUM_LINES (NUM_LINES)
) i_hof_filter_clamp_asserts (
	.sys_clk    (sys_clk),
	.rst_b      (rst_b),
	.regAddr    (regAddr),
	.regWdata   (regWdata),
	.regWr      (regWr),
	.regRd      (regRd),
	.regRdata   (regRdata),
	.dspSample  (dspSample),
	.dspValid   (dspValid),
	.supplyUnder(supplyUnder),
	.supplyOver (supplyOver),
	.memLineErr (memLineErr),
	.dacCode    (dacCode),
	.dacValid   (dacValid)
);

// ==== verification/hof_mcu_model.sv ====
/* hof_mcu_model: far-side controller sampling the output level.
 * assumes one level per dac tick, read as code over 4096 of supply. */
`timescale 1ns/1ns
module hof_mcu_model (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_b,
	// output level
	input wire logic [11:0] dacCode,
	input wire logic        dacValid,
	// last level taken
	output logic     [11:0] seenCode
);
	// sample the level at each tick
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			seenCode <= 12'h000;
		else if (dacValid)
			seenCode <= dacCode;
	end
endmodule : hof_mcu_model

// ==== verification/hof_filter_clamp_tb.sv ====
/* hof_filter_clamp_tb: self-checking bench of the filter and clamp block.
 * assumes short tick periods of 64 and 4 cycles. */
`timescale 1ns/1ns
module hof_filter_clamp_tb;
	// one clamp case
	typedef struct packed {
		logic [11:0] lo;
		logic [11:0] hi;
		logic [17:0] res;
		logic [11:0] exp;
	} hof_row_s;
	localparam hof_row_s ROWS [7] = '{
		'{12'h000, 12'hfff, 18'h00800, 12'h800},
		'{12'h100, 12'hf00, 18'h00010, 12'h100},
		'{12'h100, 12'hf00, 18'h00ff0, 12'hf00},
		'{12'h800, 12'h400, 18'h00100, 12'h400},
		'{12'h000, 12'hfff, 18'h3fff0, 12'h000},
		'{12'h000, 12'hfff, 18'h01000, 12'hfff},
		'{12'h010, 12'hff0, 18'h00800, 12'h800}};
	logic               sys_clk        = 1'b0;
	logic               rst_b          = 1'b0;
	logic        [2:0]  regAddr        = 3'h0;
	logic        [15:0] regWdata       = 16'h0000;
	logic               regWr          = 1'b0;
	logic               regRd          = 1'b0;
	logic        [15:0] regRdata;
	logic               irq;
	logic signed [15:0] adcSample      = 16'h0000;
	logic               adcValid       = 1'b0;
	logic signed [15:0] dspSample;
	logic               dspValid;
	logic        [17:0] dspResult      = 18'h00000;
	logic               dspResultValid = 1'b0;
	logic               supplyUnder    = 1'b0;
	logic               supplyOver     = 1'b0;
	logic        [7:0]  memLineErr     = 8'h00;
	logic        [11:0] dacCode;
	logic               dacValid;
	logic        [11:0] seenCode;
	logic        [15:0] rdVal;
	int                 failures       = 0;
	int                 totalChecks    = 0;

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	hof_filter_clamp #(.DSP_PERIOD(64), .DAC_PERIOD(4), .NUM_LINES(8)) i_hof_filter_clamp (
		.sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
		.adcSample(adcSample), .adcValid(adcValid), .dspSample(dspSample),
		.dspValid(dspValid), .dspResult(dspResult), .dspResultValid(dspResultValid),
		.supplyUnder(supplyUnder), .supplyOver(supplyOver), .memLineErr(memLineErr),
		.dacCode(dacCode), .dacValid(dacValid));

	hof_mcu_model i_hof_mcu_model (.sys_clk(sys_clk), .rst_b(rst_b), .dacCode(dacCode),
		.dacValid(dacValid), .seenCode(seenCode));

	// compare and count
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		totalChecks++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// bus cycles
	task automatic wrReg(input logic [2:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		regWr    <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask : wrReg

	task automatic rdReg(input logic [2:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		regRd   <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRd <= 1'b0;
		@(negedge sys_clk);
		d = regRdata;
	endtask : rdReg

	// let n edges pass, then stand mid-cycle
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : settle

	task automatic end_sim;
		$display("checks %0d mismatches %0d", totalChecks, failures);
		if (failures == 0 && totalChecks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	// watchdog
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		end_sim();
	end

	// main sequence
	initial
	begin
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		rdReg(3'h0, rdVal);
		chk("filter select", 16'h0000, rdVal);
		rdReg(3'h2, rdVal);
		chk("upper limit", 16'h0fff, rdVal);
		wrReg(3'h1, 16'hfabc);
		rdReg(3'h1, rdVal);
		chk("lower width", 16'h0abc, rdVal);
		rdReg(3'h7, rdVal);
		chk("unmapped", 16'h0000, rdVal);
		$display("test registers done");
		// clamp cases
		foreach (ROWS[i])
		begin
			wrReg(3'h1, {4'h0, ROWS[i].lo});
			wrReg(3'h2, {4'h0, ROWS[i].hi});
			@(posedge sys_clk);
			dspResult      <= ROWS[i].res;
			dspResultValid <= 1'b1;
			@(posedge sys_clk);
			dspResultValid <= 1'b0;
			settle(100);
			chk("seen level", {4'h0, ROWS[i].exp}, {4'h0, seenCode});
		end
		$display("test clamp done");
		// filter settings settle to the input exactly
		for (int k = 0; k < 7; k++)
		begin
			wrReg(3'h0, 16'(k));
			adcSample <= 16'(k * 3001 - 9000);
			adcValid  <= 1'b1;
			repeat (1500) @(posedge sys_clk);
			@(posedge dspValid);
			@(negedge sys_clk);
			chk("filtered", 16'(k * 3001 - 9000), dspSample);
		end
		@(posedge sys_clk);
		adcValid <= 1'b0;
		wrReg(3'h0, 16'h0007);
		@(posedge sys_clk);
		adcSample <= 16'h8123;
		adcValid  <= 1'b1;
		@(posedge sys_clk);
		adcValid <= 1'b0;
		@(posedge dspValid);
		@(negedge sys_clk);
		chk("bypass", 16'h8123, dspSample);
		$display("test filter done");
		// supply faults, interrupt and its clearing
		wrReg(3'h1, 16'h0010);
		wrReg(3'h2, 16'h0ff0);
		wrReg(3'h3, 16'h000f);
		wrReg(3'h4, 16'h0001);
		supplyUnder <= 1'b1;
		settle(20);
		chk("under level", 16'h0fff, {4'h0, dacCode});
		chk("irq", 16'h0001, {15'h0, irq});
		@(posedge sys_clk);
		supplyUnder <= 1'b0;
		supplyOver  <= 1'b1;
		settle(20);
		chk("over level", 16'h0fff, {4'h0, dacCode});
		@(posedge sys_clk);
		supplyOver <= 1'b0;
		settle(20);
		chk("recovered", 16'h0800, {4'h0, dacCode});
		rdReg(3'h6, rdVal);
		chk("code register", 16'h0800, rdVal);
		wrReg(3'h3, 16'h0001);
		settle(2);
		chk("irq cleared", 16'h0000, {15'h0, irq});
		// memory line errors
		@(posedge sys_clk);
		memLineErr <= 8'h04;
		settle(20);
		chk("one line", 16'h0800, {4'h0, dacCode});
		rdReg(3'h3, rdVal);
		chk("fixed flag", 16'h0002, rdVal);
		@(posedge sys_clk);
		memLineErr <= 8'h14;
		@(posedge sys_clk);
		memLineErr <= 8'h00;
		settle(20);
		chk("two lines", 16'h0fff, {4'h0, dacCode});
		rdReg(3'h3, rdVal);
		chk("fatal flag", 16'h0006, rdVal);
		$display("test diagnostics done");
		// reset in mid-run clears the latch
		@(posedge sys_clk);
		rst_b <= 1'b0;
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		settle(10);
		chk("after reset", 16'h0000, {4'h0, dacCode});
		rdReg(3'h5, rdVal);
		chk("diag after reset", 16'h0000, rdVal);
		$display("test second reset done");
		end_sim();
	end
endmodule : hof_filter_clamp_tb
